// file: src/ncs_pkg.sv
// package: register map, command codes, error codes and types of the nvm command/status block
package ncs_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [3:0] NCS_OFF_CMD    = 4'h0;
  localparam logic [3:0] NCS_OFF_PROT   = 4'h1;
  localparam logic [3:0] NCS_OFF_STAT   = 4'h2;
  localparam logic [3:0] NCS_OFF_IEN    = 4'h3;
  localparam logic [3:0] NCS_OFF_IFLG   = 4'h4;
  localparam logic [3:0] NCS_OFF_RSVD   = 4'h5;
  localparam logic [3:0] NCS_OFF_DATA0  = 4'h6;
  localparam logic [3:0] NCS_OFF_DATA1  = 4'h7;
  localparam logic [3:0] NCS_OFF_ADDR0  = 4'h8;
  localparam logic [3:0] NCS_OFF_ADDR1  = 4'h9;
  localparam logic [3:0] NCS_OFF_ADDR2  = 4'hA;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int         NCS_BIT_MAPLOCK  = 7;
  localparam int         NCS_BIT_MAP_LO   = 4;
  localparam int         NCS_BIT_DATAWP   = 2;
  localparam int         NCS_BIT_BOOT_READ_GUARD   = 1;
  localparam int         NCS_BIT_CODEWP   = 0;
  localparam int         NCS_BIT_ERR_LO   = 4;
  localparam int         NCS_BIT_EEPROM_IN_PROGRESS   = 1;
  localparam int         NCS_BIT_FLASH_IN_PROGRESS    = 0;
  localparam logic [7:0] NCS_RST_PROT     = 8'h30;
  localparam logic [7:0] NCS_RST_ZERO     = 8'h00;
  localparam logic [7:0] NCS_NOP_LO       = 8'h00;

  // ************************************************************
  // command codes
  // ************************************************************
  localparam logic [6:0] idle_code                       = 7'h00;
  localparam logic [6:0] null_operation_code             = 7'h01;
  localparam logic [6:0] flash_program_arm               = 7'h02;
  localparam logic [6:0] flash_single_page_erase_arm     = 7'h08;
  localparam logic [6:0] flash_thirtytwo_page_erase_arm  = 7'h0D;
  localparam logic [6:0] eeprom_program_arm              = 7'h12;
  localparam logic [6:0] eeprom_erase_program_arm        = 7'h13;
  localparam logic [6:0] eeprom_single_byte_erase_arm    = 7'h18;
  localparam logic [6:0] eeprom_thirtytwo_byte_erase_arm = 7'h1D;
  localparam logic [6:0] full_chip_erase                 = 7'h20;
  localparam logic [6:0] whole_eeprom_erase              = 7'h30;

  // ************************************************************
  // error codes
  // ************************************************************
  localparam logic [2:0] no_error_code            = 3'h0;
  localparam logic [2:0] unsupported_op_error     = 3'h1;
  localparam logic [2:0] protected_section_error  = 3'h2;
  localparam logic [2:0] op_switch_conflict_error = 3'h3;

  // ************************************************************
  // flash and eeprom sections and types
  // ************************************************************
  localparam logic [1:0] NCS_SEC_BOOT = 2'h0;
  localparam logic [1:0] NCS_SEC_CODE = 2'h1;
  localparam logic [1:0] NCS_SEC_DATA = 2'h2;
  localparam logic [1:0] NCS_SEC_EE   = 2'h3;
  localparam int         NCS_UNLOCK_WIN = 4;

  typedef enum logic [1:0] {
    NCS_MEM_IDLE,
    NCS_MEM_FLASH,
    NCS_MEM_EE
  } ncs_mem_t;

  // store from the core toward the memory array
  typedef struct packed {
    logic        valid;
    logic [1:0]  section;
    logic [23:0] addr;
  } ncs_store_t;

  // completed read from the array
  typedef struct packed {
    logic        valid;
    logic [23:0] addr;
    logic [15:0] data;
  } ncs_rd_t;

  // operation start toward the sequencer
  typedef struct packed {
    logic        valid;
    logic [6:0]  cmd;
    logic [23:0] addr;
    logic        keep_ee;
  } ncs_op_t;

endpackage

// file: src/ncs_regs.sv
// nvm command, protection and status register front end
// Functional notes
// - seven-bit command field in bits 6:0 of control register at 0x00.
// - chip erase 0x20 and eeprom erase 0x30 start on command write.
// - other codes only arm; a store to memory starts the operation.
// - changing command without passing 0x00/0x01 records collision error 0x3.
// - flash codes 0x02 write, 0x08 page erase, 0x09-0x0D multi-page erase.
// - eeprom codes 0x12, 0x13, 0x18, 0x19-0x1D byte erases.
// - chip erase only from debug port; fuse keeps eeprom intact.
// - reserved command values raise error 0x1.
// - control B resets to 0x30; bit 7 locks mapping until reset.
// - mapping field writable without the unlock sequence.
// - bit 2 blocks app data section updates until reset.
// - bit 0 blocks app code section updates until reset.
// - boot read guard returns zero to reads, no-operation to fetches; here only boot-section fetches read 0x0000, read data passes unguarded.
// - boot read guard written only from boot; effective after leaving boot.
// - write to guarded section records error 0x2 and is dropped.
// - error field bits 6:4 holds last error; writing zero clears it.
// - status bit 1 is eeprom busy.
// - status bit 0 is flash busy.
// - protected bits change only within four instructions after unlock key.
// - eeprom idle flag set while eeprom idle; write 1 clears.
// - 16-bit data register captures last read value.
// - 24-bit address register holds last accessed location.
//
// Chosen here: strobed register access.
`timescale 1ns/100ps
module ncs_regs
  import ncs_pkg::*;
(
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_srst,
  // register port
  input  wire logic [3:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic        i_from_dbg,
  output logic      [7:0]  o_rdata,
  // unlock and execution context
  input  wire logic        i_unlock_key,
  input  wire logic        i_instr_done,
  input  wire logic        i_exec_boot,
  input  wire logic        i_fuse_keep_ee,
  // memory traffic
  input  wire ncs_store_t  i_store,
  input  wire ncs_rd_t     i_rdback,
  input  wire logic        i_fetch,
  input  wire logic [1:0]  i_fetch_sec,
  input  wire logic [15:0] i_fetch_raw,
  input  wire logic        i_flash_busy,
  input  wire logic        i_ee_busy,
  // results
  output ncs_op_t          o_op,
  output logic      [15:0] o_fetch_word,
  output logic      [1:0]  o_map_window,
  output logic             o_irq
);

  // ************************************************************
  // state
  // ************************************************************
  logic [6:0]  cmd_r;
  logic        maplock_r;
  logic [1:0]  map_r;
  logic        datawp_r;
  logic        boot_read_guard_r;
  logic        codewp_r;
  logic        rp_live_r;
  logic [2:0]  err_r;
  logic        ien_r;
  logic        eeidle_r;
  logic [15:0] data_r;
  logic [23:0] addr_r;
  logic [2:0]  unlk_cnt_r;
  logic        flash_in_progress_r;
  logic        eeprom_in_progress_r;
  logic        boot_prev_r;

  logic        unlocked;
  logic        wr_cmd;
  logic        wr_prot;
  logic        cmd_valid;
  logic        cmd_ee;
  logic        cmd_flash;
  logic        chip_ok;
  logic        immediate;
  logic        switch_bad;
  logic        sec_guarded;
  logic        store_go;
  logic [2:0]  err_nxt;
  logic [7:0]  rd_nxt;

  // ************************************************************
  // unlock window
  // ************************************************************
  // counts instructions, not cycles, so slow instructions keep the window
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      unlk_cnt_r <= 3'h0;
    end else if (i_unlock_key) begin
      unlk_cnt_r <= 3'(NCS_UNLOCK_WIN);
    end else if (i_instr_done && unlk_cnt_r != 3'h0) begin
      unlk_cnt_r <= unlk_cnt_r - 3'h1;
    end
  end

  assign unlocked = (unlk_cnt_r != 3'h0);
  assign wr_cmd   = i_wr && i_addr == NCS_OFF_CMD && unlocked;
  assign wr_prot  = i_wr && i_addr == NCS_OFF_PROT;

  // ************************************************************
  // command decode
  // ************************************************************
  always_comb begin
    cmd_flash = (i_wdata[6:0] == flash_program_arm) ||
                (i_wdata[6:0] >= flash_single_page_erase_arm &&
                 i_wdata[6:0] <= flash_thirtytwo_page_erase_arm);
    cmd_ee    = (i_wdata[6:0] == eeprom_program_arm) ||
                (i_wdata[6:0] == eeprom_erase_program_arm) ||
                (i_wdata[6:0] >= eeprom_single_byte_erase_arm &&
                 i_wdata[6:0] <= eeprom_thirtytwo_byte_erase_arm);
    // chip erase from the core side falls through as a reserved code
    chip_ok   = (i_wdata[6:0] == full_chip_erase) && i_from_dbg;
    immediate = chip_ok || (i_wdata[6:0] == whole_eeprom_erase);
    cmd_valid = cmd_flash || cmd_ee || immediate ||
                i_wdata[6:0] == idle_code || i_wdata[6:0] == null_operation_code;
    // rewriting the armed code is not a switch, so it raises no collision
    switch_bad = cmd_valid && cmd_r != idle_code && cmd_r != null_operation_code &&
                 i_wdata[6:0] != idle_code && i_wdata[6:0] != null_operation_code &&
                 i_wdata[6:0] != cmd_r;
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      cmd_r <= idle_code;
    end else if (wr_cmd && cmd_valid && !switch_bad) begin
      cmd_r <= i_wdata[6:0];
    end
  end

  // ************************************************************
  // operation start
  // ************************************************************
  always_comb begin
    case (i_store.section)
      NCS_SEC_CODE: sec_guarded = codewp_r;
      NCS_SEC_DATA: sec_guarded = datawp_r;
      default:      sec_guarded = 1'b0;
    endcase
  end

  // a store only launches work when the armed command matches the target memory
  assign store_go = i_store.valid && !sec_guarded &&
                    (i_store.section == NCS_SEC_EE ?
                     (cmd_r >= eeprom_program_arm && cmd_r <= eeprom_thirtytwo_byte_erase_arm) :
                     (cmd_r >= flash_program_arm && cmd_r <= flash_thirtytwo_page_erase_arm));

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_op <= '0;
    end else begin
      o_op.valid   <= (wr_cmd && immediate && !switch_bad) || store_go;
      o_op.cmd     <= (wr_cmd && immediate) ? i_wdata[6:0] : cmd_r;
      o_op.addr    <= i_store.addr;
      o_op.keep_ee <= i_fuse_keep_ee;
    end
  end

  // ************************************************************
  // protection and mapping
  // ************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      maplock_r <= NCS_RST_PROT[NCS_BIT_MAPLOCK];
      map_r     <= NCS_RST_PROT[NCS_BIT_MAP_LO+1:NCS_BIT_MAP_LO];
    end else if (wr_prot) begin
      if (!maplock_r) begin
        map_r <= i_wdata[NCS_BIT_MAP_LO+1:NCS_BIT_MAP_LO];
      end
      if (unlocked && i_wdata[NCS_BIT_MAPLOCK]) begin
        maplock_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      datawp_r <= NCS_RST_PROT[NCS_BIT_DATAWP];
      codewp_r <= NCS_RST_PROT[NCS_BIT_CODEWP];
      boot_read_guard_r <= NCS_RST_PROT[NCS_BIT_BOOT_READ_GUARD];
    end else if (wr_prot && unlocked) begin
      datawp_r <= datawp_r | i_wdata[NCS_BIT_DATAWP];
      codewp_r <= codewp_r | i_wdata[NCS_BIT_CODEWP];
      boot_read_guard_r <= boot_read_guard_r | (i_wdata[NCS_BIT_BOOT_READ_GUARD] & i_exec_boot);
    end
  end

  // guard goes live on the first instruction outside boot after being set
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rp_live_r   <= 1'b0;
      boot_prev_r <= 1'b0;
    end else begin
      boot_prev_r <= i_exec_boot;
      if (boot_read_guard_r && boot_prev_r && !i_exec_boot) begin
        rp_live_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_fetch_word <= 16'h0000;
      o_map_window <= NCS_RST_PROT[NCS_BIT_MAP_LO+1:NCS_BIT_MAP_LO];
    end else begin
      o_map_window <= map_r;
      if (i_fetch) begin
        o_fetch_word <= (rp_live_r && i_fetch_sec == NCS_SEC_BOOT) ?
                        {NCS_NOP_LO, NCS_NOP_LO} : i_fetch_raw;
      end
    end
  end

  // ************************************************************
  // status, flags, data and address
  // ************************************************************
  // later ifs win: command error over guard error over software clear
  always_comb begin
    err_nxt = err_r;
    if (i_wr && i_addr == NCS_OFF_STAT && i_wdata[6:4] == no_error_code) begin
      err_nxt = no_error_code;
    end
    if (i_store.valid && sec_guarded) begin
      err_nxt = protected_section_error;
    end
    if (wr_cmd && !cmd_valid) begin
      err_nxt = unsupported_op_error;
    end else if (wr_cmd && switch_bad) begin
      err_nxt = op_switch_conflict_error;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      err_r    <= no_error_code;
      flash_in_progress_r  <= 1'b0;
      eeprom_in_progress_r <= 1'b0;
      ien_r    <= 1'b0;
      eeidle_r <= 1'b0;
    end else begin
      err_r    <= err_nxt;
      flash_in_progress_r  <= i_flash_busy;
      eeprom_in_progress_r <= i_ee_busy;
      if (i_wr && i_addr == NCS_OFF_IEN) begin
        ien_r <= i_wdata[0];
      end
      // idle sets win over the software clear
      if (!i_ee_busy) begin
        eeidle_r <= 1'b1;
      end else if (i_wr && i_addr == NCS_OFF_IFLG && i_wdata[0]) begin
        eeidle_r <= 1'b0;
      end
    end
  end

  // hardware traffic owns the address over a software write in the same cycle
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      data_r <= 16'h0000;
      addr_r <= 24'h000000;
    end else if (i_rdback.valid) begin
      data_r <= i_rdback.data;
      addr_r <= i_rdback.addr;
    end else if (i_store.valid) begin
      addr_r <= i_store.addr;
    end else if (i_wr) begin
      case (i_addr)
        NCS_OFF_DATA0: data_r[7:0]   <= i_wdata;
        NCS_OFF_DATA1: data_r[15:8]  <= i_wdata;
        NCS_OFF_ADDR0: addr_r[7:0]   <= i_wdata;
        NCS_OFF_ADDR1: addr_r[15:8]  <= i_wdata;
        NCS_OFF_ADDR2: addr_r[23:16] <= i_wdata;
        default:       addr_r        <= addr_r;
      endcase
    end
  end

  // ************************************************************
  // read port
  // ************************************************************
  // reserved offsets and unused bits read as zero
  always_comb begin
    case (i_addr)
      NCS_OFF_CMD:   rd_nxt = {1'b0, cmd_r};
      NCS_OFF_PROT:  rd_nxt = {maplock_r, 1'b0, map_r, 1'b0, datawp_r, boot_read_guard_r, codewp_r};
      NCS_OFF_STAT:  rd_nxt = {1'b0, err_r, 2'b00, eeprom_in_progress_r, flash_in_progress_r};
      NCS_OFF_IEN:   rd_nxt = {7'h00, ien_r};
      NCS_OFF_IFLG:  rd_nxt = {7'h00, eeidle_r};
      NCS_OFF_DATA0: rd_nxt = data_r[7:0];
      NCS_OFF_DATA1: rd_nxt = data_r[15:8];
      NCS_OFF_ADDR0: rd_nxt = addr_r[7:0];
      NCS_OFF_ADDR1: rd_nxt = addr_r[15:8];
      NCS_OFF_ADDR2: rd_nxt = addr_r[23:16];
      default:       rd_nxt = NCS_RST_ZERO;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_rdata <= NCS_RST_ZERO;
      o_irq   <= 1'b0;
    end else begin
      // zero outside the answer cycle keeps a stale byte off the shared bus
      o_rdata <= i_rd ? rd_nxt : NCS_RST_ZERO;
      o_irq   <= ien_r & eeidle_r;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  // antecedents leave out same-cycle events of higher error priority
  a_lock_holds_map: assert property (@(posedge i_mclk) disable iff (i_srst)
    maplock_r |=> $stable(map_r)) else $error("map changed while locked");
  a_lock_sticky: assert property (@(posedge i_mclk) disable iff (i_srst)
    maplock_r |=> maplock_r) else $error("map lock cleared");
  a_codewp_sticky: assert property (@(posedge i_mclk) disable iff (i_srst)
    codewp_r |=> codewp_r) else $error("code guard cleared");
  a_datawp_sticky: assert property (@(posedge i_mclk) disable iff (i_srst)
    datawp_r |=> datawp_r) else $error("data guard cleared");
  a_guard_no_op: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_store.valid && sec_guarded && !wr_cmd) |=> !o_op.valid && err_r == protected_section_error)
    else $error("guarded store not refused");
  a_bad_cmd_err: assert property (@(posedge i_mclk) disable iff (i_srst)
    (wr_cmd && !cmd_valid) |=> err_r == unsupported_op_error && $stable(cmd_r))
    else $error("reserved command accepted");
  a_collision: assert property (@(posedge i_mclk) disable iff (i_srst)
    (wr_cmd && switch_bad) |=> err_r == op_switch_conflict_error)
    else $error("collision not flagged");
  a_no_unlock: assert property (@(posedge i_mclk) disable iff (i_srst)
    (unlk_cnt_r == 3'h0 && !i_unlock_key) |=> $stable(cmd_r) && $stable(codewp_r))
    else $error("protected write without unlock");
  a_immediate_go: assert property (@(posedge i_mclk) disable iff (i_srst)
    (wr_cmd && i_wdata[6:0] == whole_eeprom_erase && !switch_bad) |=> o_op.valid)
    else $error("eeprom erase not started");
  a_chip_dbg_only: assert property (@(posedge i_mclk) disable iff (i_srst)
    (wr_cmd && i_wdata[6:0] == full_chip_erase && !i_from_dbg && !i_store.valid) |=>
    !o_op.valid && err_r == unsupported_op_error) else $error("core chip erase accepted");
  a_arm_no_op: assert property (@(posedge i_mclk) disable iff (i_srst)
    (wr_cmd && (cmd_flash || cmd_ee) && !i_store.valid) |=> !o_op.valid)
    else $error("arm code started work");
  a_err_clear: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_wr && i_addr == NCS_OFF_STAT && i_wdata[6:4] == no_error_code && !i_store.valid)
    |=> err_r == no_error_code) else $error("error field not cleared");
  a_fetch_nop: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_fetch && rp_live_r && i_fetch_sec == NCS_SEC_BOOT) |=> o_fetch_word == 16'h0000)
    else $error("guarded fetch leaked");
  a_rdata_idle: assert property (@(posedge i_mclk) disable iff (i_srst)
    !i_rd |=> o_rdata == NCS_RST_ZERO)
    else $error("read data outside answer cycle");
  a_boot_read_guard_gate: assert property (@(posedge i_mclk) disable iff (i_srst)
    (!i_exec_boot && !boot_read_guard_r) |=> !boot_read_guard_r)
    else $error("boot guard set outside boot");
  a_idle_flag_set: assert property (@(posedge i_mclk) disable iff (i_srst)
    !i_ee_busy |=> eeidle_r)
    else $error("idle flag not set");
  a_map_free: assert property (@(posedge i_mclk) disable iff (i_srst)
    (wr_prot && !maplock_r) |=> map_r == $past(i_wdata[NCS_BIT_MAP_LO+1:NCS_BIT_MAP_LO]))
    else $error("map write refused");

endmodule

// file: tb/ncs_seq_model.sv
// partner model: sequencer that turns started operations into busy levels
`timescale 1ns/100ps
module ncs_seq_model
  import ncs_pkg::*;
#(
  parameter int BUSY_CYC = 20
) (
  // clock and reset
  input  wire logic    i_mclk,
  input  wire logic    i_srst,
  // operation start from the block
  input  wire ncs_op_t i_op,
  // busy levels back to the block
  output logic         o_flash_busy,
  output logic         o_ee_busy
);
  logic [7:0] cnt_r;
  logic       fl_r;
  logic       ee_r;
  logic       ee_hit;
  // chip erase leaves the eeprom alone when the fuse asks for it
  assign ee_hit = (i_op.cmd[6:4] == 3'h1) || (i_op.cmd == whole_eeprom_erase) ||
                  ((i_op.cmd == full_chip_erase) && !i_op.keep_ee);
  // busy follows only a started operation, never an arm code alone
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      cnt_r <= 8'h00;
      fl_r  <= 1'b0;
      ee_r  <= 1'b0;
    end else if (i_op.valid) begin
      cnt_r <= 8'(BUSY_CYC);
      fl_r  <= (i_op.cmd[6:4] == 3'h0) || (i_op.cmd == full_chip_erase);
      ee_r  <= ee_hit;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
  assign o_flash_busy = fl_r && (cnt_r != 8'h00);
  assign o_ee_busy    = ee_r && (cnt_r != 8'h00);
endmodule

// file: tb/tb.sv
// testbench: register-level sequences against the nvm command/status block
`timescale 1ns/100ps
module tb;
  import ncs_pkg::*;
  // ************************************************************
  // signals
  // ************************************************************
  logic        i_mclk, i_srst, i_wr, i_rd, i_from_dbg, i_unlock_key;
  logic        i_instr_done, i_exec_boot, i_fuse_keep_ee, i_fetch;
  logic        i_flash_busy, i_ee_busy, o_irq;
  logic [3:0]  i_addr;
  logic [7:0]  i_wdata, o_rdata;
  logic [1:0]  i_fetch_sec, o_map_window;
  logic [15:0] i_fetch_raw, o_fetch_word;
  ncs_store_t  i_store;
  ncs_rd_t     i_rdback;
  ncs_op_t     o_op, last_op;
  int          err_total = 0, checked = 0, ops = 0, exp_ops = 0, k;
  logic [6:0]  codes [17] = '{7'h02, 7'h08, 7'h09, 7'h0A, 7'h0B, 7'h0C, 7'h0D, 7'h12,
                              7'h13, 7'h18, 7'h19, 7'h1A, 7'h1B, 7'h1C, 7'h1D, 7'h12, 7'h02};

  ncs_regs u_ncs_regs (.i_mclk, .i_srst, .i_addr, .i_wdata, .i_wr, .i_rd, .i_from_dbg,
    .o_rdata, .i_unlock_key, .i_instr_done, .i_exec_boot, .i_fuse_keep_ee, .i_store,
    .i_rdback, .i_fetch, .i_fetch_sec, .i_fetch_raw, .i_flash_busy, .i_ee_busy, .o_op,
    .o_fetch_word, .o_map_window, .o_irq);
  ncs_seq_model u_ncs_seq_model (.i_mclk, .i_srst, .i_op(o_op),
    .o_flash_busy(i_flash_busy), .o_ee_busy(i_ee_busy));

  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    if (o_op.valid === 1'b1) begin
      ops     <= ops + 1;
      last_op <= o_op;
    end
  end
  // ************************************************************
  // tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic dbg = 1'b0);
    @(posedge i_mclk);
    i_addr     <= a;
    i_wdata    <= d;
    i_wr       <= 1'b1;
    i_from_dbg <= dbg;
    @(posedge i_mclk);
    i_wr       <= 1'b0;
    i_from_dbg <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask
  // key pulse then the protected write inside the window
  task automatic uwr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_unlock_key <= 1'b1;
    @(posedge i_mclk);
    i_unlock_key <= 1'b0;
    wr(a, d);
  endtask
  task automatic st(input logic [1:0] s, input logic [23:0] a);
    @(posedge i_mclk);
    i_store <= '{1'b1, s, a};
    @(posedge i_mclk);
    i_store.valid <= 1'b0;
  endtask
  task automatic fe(input logic [1:0] s, input logic [15:0] raw, input logic [15:0] e);
    @(posedge i_mclk);
    i_fetch     <= 1'b1;
    i_fetch_sec <= s;
    i_fetch_raw <= raw;
    @(posedge i_mclk);
    i_fetch <= 1'b0;
    #1 chk(o_fetch_word, e);
  endtask
  task automatic ck_ops();
    @(posedge i_mclk);
    #1 chk(ops, exp_ops);
  endtask
  // bounded wait for the sequencer, then let the busy copy settle
  task automatic wait_idle();
    for (k = 0; k < 200 && (i_flash_busy === 1'b1 || i_ee_busy === 1'b1); k++)
      @(posedge i_mclk);
    if (k == 200) begin
      err_total++;
      $display("Error at %0t: sequencer still busy", $time);
      report_and_stop();
    end
    repeat (2) @(posedge i_mclk);
  endtask
  // ************************************************************
  // sequence
  // ************************************************************
  initial begin
    {i_srst, i_wr, i_rd, i_from_dbg, i_unlock_key, i_instr_done} = 6'h21;
    {i_exec_boot, i_fuse_keep_ee, i_fetch, i_addr, i_wdata} = '0;
    {i_fetch_sec, i_fetch_raw, i_store, i_rdback} = '0;
    repeat (4) @(posedge i_mclk);
    i_srst <= 1'b0;
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h30);
    rd(4'h2, 8'h00);
    rd(4'h4, 8'h01);
    chk(o_map_window, 2'h3);
    wr(4'h0, 8'h02);
    rd(4'h0, 8'h00);
    @(posedge i_mclk);
    i_unlock_key <= 1'b1;
    @(posedge i_mclk);
    i_unlock_key <= 1'b0;
    i_instr_done <= 1'b1;
    repeat (4) @(posedge i_mclk);
    wr(4'h0, 8'h02);
    rd(4'h0, 8'h00);
    foreach (codes[j]) begin
      uwr(4'h0, {1'b0, codes[j]});
      rd(4'h0, {1'b0, codes[j]});
      rd(4'h2, 8'h00);
      uwr(4'h0, {7'h00, j[0]});
    end
    uwr(4'h0, 8'h82);
    rd(4'h0, 8'h02);
    st(NCS_SEC_CODE, 24'h001234);
    exp_ops++;
    ck_ops();
    chk({last_op.cmd, last_op.addr}, {7'h02, 24'h001234});
    rd(4'h2, 8'h01);
    wait_idle();
    uwr(4'h0, 8'h08);
    rd(4'h0, 8'h02);
    rd(4'h2, 8'h30);
    wr(4'h2, 8'h00);
    rd(4'h2, 8'h00);
    uwr(4'h0, 8'h00);
    uwr(4'h0, 8'h05);
    rd(4'h0, 8'h00);
    rd(4'h2, 8'h10);
    wr(4'h2, 8'h00);
    uwr(4'h0, 8'h12);
    st(NCS_SEC_EE, 24'h000040);
    exp_ops++;
    ck_ops();
    chk(last_op.cmd, 7'h12);
    rd(4'h2, 8'h02);
    wait_idle();
    uwr(4'h0, 8'h00);
    uwr(4'h0, 8'h20);
    ck_ops();
    rd(4'h2, 8'h10);
    wr(4'h2, 8'h00);
    i_fuse_keep_ee <= 1'b1;
    @(posedge i_mclk);
    i_unlock_key <= 1'b1;
    @(posedge i_mclk);
    i_unlock_key <= 1'b0;
    wr(4'h0, 8'h20, 1'b1);
    exp_ops++;
    ck_ops();
    chk({last_op.cmd, last_op.keep_ee}, {7'h20, 1'b1});
    wait_idle();
    uwr(4'h0, 8'h00);
    wr(4'h3, 8'hFF);
    rd(4'h3, 8'h01);
    chk(o_irq, 1'b1);
    uwr(4'h0, 8'h30);
    exp_ops++;
    ck_ops();
    wr(4'h4, 8'h01);
    rd(4'h4, 8'h00);
    chk(o_irq, 1'b0);
    wait_idle();
    rd(4'h4, 8'h01);
    uwr(4'h0, 8'h00);
    uwr(4'h1, 8'h35);
    rd(4'h1, 8'h35);
    uwr(4'h0, 8'h02);
    st(NCS_SEC_CODE, 24'h000100);
    ck_ops();
    rd(4'h2, 8'h20);
    wr(4'h2, 8'h00);
    st(NCS_SEC_DATA, 24'h00F000);
    ck_ops();
    rd(4'h2, 8'h20);
    wr(4'h2, 8'h00);
    uwr(4'h1, 8'h30);
    rd(4'h1, 8'h35);
    st(NCS_SEC_BOOT, 24'h000010);
    exp_ops++;
    ck_ops();
    wait_idle();
    wr(4'h1, 8'h15);
    rd(4'h1, 8'h15);
    chk(o_map_window, 2'h1);
    uwr(4'h1, 8'h95);
    wr(4'h1, 8'h25);
    rd(4'h1, 8'h95);
    chk(o_map_window, 2'h1);
    uwr(4'h1, 8'h97);
    rd(4'h1, 8'h95);
    @(posedge i_mclk);
    i_exec_boot <= 1'b1;
    uwr(4'h1, 8'h97);
    rd(4'h1, 8'h97);
    fe(NCS_SEC_BOOT, 16'hABCD, 16'hABCD);
    @(posedge i_mclk);
    i_exec_boot <= 1'b0;
    fe(NCS_SEC_BOOT, 16'hABCD, 16'h0000);
    fe(NCS_SEC_CODE, 16'h1111, 16'h1111);
    @(posedge i_mclk);
    i_rdback <= '{1'b1, 24'h012345, 16'hBEEF};
    @(posedge i_mclk);
    i_rdback.valid <= 1'b0;
    rd(4'h6, 8'hEF);
    rd(4'h7, 8'hBE);
    rd(4'h8, 8'h45);
    rd(4'h9, 8'h23);
    rd(4'hA, 8'h01);
    wr(4'h6, 8'h5A);
    rd(4'h6, 8'h5A);
    wr(4'h5, 8'hFF);
    rd(4'h5, 8'h00);
    @(posedge i_mclk);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_srst <= 1'b0;
    rd(4'h1, 8'h30);
    chk(o_map_window, 2'h3);
    rd(4'h4, 8'h01);
    report_and_stop();
  end
endmodule
